// ### src/scc_pkg.sv
// constants, types and helpers of the self-calibration correction stage
package scc_pkg;
	localparam int unsigned WORD_W        = 24;
	localparam int unsigned AXI_AW        = 8;
	localparam int unsigned AXI_DW        = 32;
	localparam int unsigned GAIN_SETTINGS = 8;
	localparam int unsigned PIPE_LAT      = 3;

	typedef logic [WORD_W-1:0] scc_word_t;

	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_EXT_OFFSET_B = 6'h14;
	localparam logic [5:0] IDX_EXT_GAIN_B   = 6'h16;
	localparam logic [5:0] IDX_INT_OFFSET   = 6'h17;
	localparam logic [5:0] IDX_INT_GAIN_X1  = 6'h18;
	localparam logic [5:0] IDX_INT_GAIN_X2  = 6'h19;
	localparam logic [5:0] IDX_INT_GAIN_X4  = 6'h1a;
	localparam logic [5:0] IDX_INT_GAIN_TOP = 6'h1f;
	localparam logic [5:0] IDX_CTRL         = 6'h30;
	localparam logic [5:0] IDX_RESULT       = 6'h31;
	localparam int unsigned IDX_LSB         = 2;

	// control word, bit 6 down to bit 0
	localparam int unsigned CTRL_W = 7;
	typedef struct packed {
		logic       ext_gain_en;
		logic       ext_offset_en;
		logic [2:0] gain_sel;
		logic       polarity_select;
		logic       internal_offset_disable;
	} scc_ctrl_t;

	localparam scc_word_t OFFSET_RST = 24'h000000;
	localparam scc_word_t GAIN_UNITY = 24'h800000;
	localparam scc_ctrl_t CTRL_RST   = 7'h00;
	localparam scc_word_t WORD_MAX   = 24'h7fffff;
	localparam scc_word_t WORD_MIN   = 24'h800000;
	localparam int unsigned GAIN_FRAC = 23;
	localparam logic signed [48:0] ROUND_HALF = 49'sh000000400000;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		K_OFF, K_GAIN, K_EXT_OFF, K_EXT_GAIN, K_CTRL, K_RES
	} scc_kind_t;

	typedef struct packed {
		logic      hit;
		scc_kind_t kind;
		logic [2:0] gidx;
	} scc_dec_t;

	typedef struct packed {
		logic      valid;
		scc_word_t data;
	} scc_sample_t;

	// on-demand calibration result: target 0 offset, 1 gain
	typedef struct packed {
		logic       valid;
		logic       target;
		logic [2:0] gidx;
		scc_word_t  data;
	} scc_cal_t;

	typedef struct packed {
		scc_word_t                    off;
		scc_word_t [GAIN_SETTINGS-1:0] gain;
		scc_word_t                    ext_off;
		scc_word_t                    ext_gain;
		scc_ctrl_t                    ctrl;
		logic                         aw_got;
		logic [AXI_AW-1:0]            awaddr;
		logic                         w_got;
		logic [AXI_DW-1:0]            wdata;
		logic [3:0]                   wstrb;
		logic                         awready;
		logic                         wready;
		logic                         bvalid;
		logic [1:0]                   bresp;
		logic                         arready;
		logic                         rvalid;
		logic [1:0]                   rresp;
		logic [AXI_DW-1:0]            rdata;
		scc_sample_t                  s1;
		scc_sample_t                  s2;
		scc_sample_t                  res;
	} scc_state_t;

	localparam scc_state_t STATE_RST = '{
		off: OFFSET_RST,
		gain: {GAIN_SETTINGS{GAIN_UNITY}},
		ext_off: OFFSET_RST,
		ext_gain: GAIN_UNITY,
		ctrl: CTRL_RST,
		default: '0
	};

	function automatic scc_word_t sat_word(input logic signed [25:0] v);
		if (v > 26'sh07fffff) begin
			return WORD_MAX;
		end else if (v < -26'sh0800000) begin
			return WORD_MIN;
		end
		return v[23:0];
	endfunction

	function automatic scc_word_t sat_sub(input scc_word_t a, input scc_word_t b);
		logic signed [25:0] d;
		d = 26'($signed(a)) - 26'($signed(b));
		return sat_word(d);
	endfunction

	function automatic scc_word_t sat_dbl(input scc_word_t a);
		logic signed [25:0] d;
		d = 26'($signed(a)) + 26'($signed(a));
		return sat_word(d);
	endfunction
endpackage

// ### src/scc_gain_mul.sv
// unsigned q1.23 gain times signed word, rounded and saturated
`timescale 1ns/1ns
module scc_gain_mul
	import scc_pkg::*;
(
	// operands
	input  wire scc_word_t din,
	input  wire scc_word_t gain,
	// product
	output wire scc_word_t dout
);
	logic signed [48:0] prod;
	logic signed [25:0] scaled;

	// gain is unsigned, binary point after the top bit [RQ7] [RQ8] [RQ10]
	assign prod   = 49'($signed(din)) * 49'($signed({1'b0, gain}));
	// half-lsb rounding keeps the error well inside two lsb [RQ11]
	assign scaled = 26'((prod + ROUND_HALF) >>> GAIN_FRAC);
	assign dout   = sat_word(scaled); // [RQ14]
endmodule

// ### src/scc_top.sv
// self-calibration correction datapath with axi4-lite register slave
`timescale 1ns/1ns
// Behaviour
// RQ1: skip internal offset when disable bit set
// RQ2: internal offset is always two's complement
// RQ3: offset holds until write or calibration
// RQ4: internal offset, internal gain, then system corrections
// RQ5: internal offset precedes unipolar doubling
// RQ6: eight gain registers, selected by gain setting
// RQ7: gain unsigned q1.23, msb weighs one
// RQ8: gain meaning independent of polarity/format
// RQ9: gain holds until write or calibration
// RQ10: gain factor reaches just below two
// RQ11: residual gain error within two lsb
// RQ12: gain registers map one to one
// RQ13: system offset before system gain and scaling
// RQ14: saturate instead of wrapping
module scc_top
	import scc_pkg::*;
(
	// clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// axi4-lite write address and data
	input  wire logic [AXI_AW-1:0] awaddr,
	input  wire logic              awvalid,
	output wire logic              awready,
	input  wire logic [AXI_DW-1:0] wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output wire logic              wready,
	// axi4-lite write response
	output wire logic [1:0]        bresp,
	output wire logic              bvalid,
	input  wire logic              bready,
	// axi4-lite read
	input  wire logic [AXI_AW-1:0] araddr,
	input  wire logic              arvalid,
	output wire logic              arready,
	output wire logic [AXI_DW-1:0] rdata,
	output wire logic [1:0]        rresp,
	output wire logic              rvalid,
	input  wire logic              rready,
	// raw conversion results
	input  wire scc_sample_t       raw_in,
	// on-demand calibration results
	input  wire scc_cal_t          cal_in,
	// corrected results
	output wire scc_word_t         result_data,
	output wire logic              result_valid
);
	scc_state_t st;
	scc_state_t n;
	scc_dec_t   wdec;
	scc_dec_t   rdec;
	logic       wr_commit;
	scc_word_t  off_term;
	scc_word_t  sub1;
	scc_word_t  mul1;
	scc_word_t  sub2;
	scc_word_t  gain2;
	scc_word_t  mul2;

	function automatic scc_dec_t decode(input logic [AXI_AW-1:0] a);
		scc_dec_t   d;
		logic [5:0] idx;
		idx    = a[AXI_AW-1:IDX_LSB];
		d.hit  = 1'b1;
		d.kind = K_CTRL;
		d.gidx = idx[2:0];
		if (idx == IDX_INT_OFFSET) begin
			d.kind = K_OFF;
		end else if (idx >= IDX_INT_GAIN_X1 && idx <= IDX_INT_GAIN_TOP) begin
			d.kind = K_GAIN; // [RQ12]
		end else if (idx == IDX_EXT_OFFSET_B) begin
			d.kind = K_EXT_OFF;
		end else if (idx == IDX_EXT_GAIN_B) begin
			d.kind = K_EXT_GAIN;
		end else if (idx == IDX_RESULT) begin
			d.kind = K_RES;
		end else if (idx != IDX_CTRL) begin
			d.hit = 1'b0;
		end
		return d;
	endfunction

	function automatic scc_word_t merge(
		input scc_word_t         old,
		input logic [AXI_DW-1:0] d,
		input logic [3:0]        s
	);
		scc_word_t r;
		r = old;
		for (int i = 0; i < 3; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// datapath operands, first stage internal, second stage system
	assign off_term = st.ctrl.internal_offset_disable ? OFFSET_RST : st.off; // [RQ1]
	assign sub1     = sat_sub(raw_in.data, off_term); // [RQ2] [RQ14]
	assign sub2     = sat_sub(st.s1.data, st.ctrl.ext_offset_en ? st.ext_off : OFFSET_RST);
	assign gain2    = st.ctrl.ext_gain_en ? st.ext_gain : GAIN_UNITY;

	scc_gain_mul u_int_gain ( // [RQ7] [RQ8] [RQ10] [RQ11]
		.din  (sub1),
		.gain (st.gain[st.ctrl.gain_sel]), // [RQ6]
		.dout (mul1)
	);

	scc_gain_mul u_ext_gain (
		.din  (sub2),
		.gain (gain2),
		.dout (mul2)
	);

	always_comb begin
		n         = st;
		wr_commit = 1'b0;
		wdec      = decode(st.awaddr);
		rdec      = decode(araddr);
		// write address and data, taken in either order
		if (awvalid && st.awready) begin
			n.aw_got = 1'b1;
			n.awaddr = awaddr;
		end
		if (wvalid && st.wready) begin
			n.w_got = 1'b1;
			n.wdata = wdata;
			n.wstrb = wstrb;
		end
		if (st.bvalid && bready) begin
			n.bvalid = 1'b0;
		end
		if (n.aw_got && n.w_got) begin
			wr_commit = 1'b1;
			wdec      = decode(n.awaddr);
			n.aw_got  = 1'b0;
			n.w_got   = 1'b0;
			n.bvalid  = 1'b1;
			n.bresp   = (wdec.hit && wdec.kind != K_RES) ? RESP_OKAY : RESP_SLVERR;
			if (wdec.hit) begin
				case (wdec.kind)
					K_OFF: begin
						n.off = merge(st.off, n.wdata, n.wstrb); // [RQ3]
					end
					K_GAIN: begin
						n.gain[wdec.gidx] = merge(st.gain[wdec.gidx], n.wdata, n.wstrb); // [RQ9]
					end
					K_EXT_OFF: begin
						n.ext_off = merge(st.ext_off, n.wdata, n.wstrb);
					end
					K_EXT_GAIN: begin
						n.ext_gain = merge(st.ext_gain, n.wdata, n.wstrb);
					end
					K_CTRL: begin
						if (n.wstrb[0]) begin
							n.ctrl = scc_ctrl_t'(n.wdata[CTRL_W-1:0]);
						end
					end
					default: begin
					end
				endcase
			end
		end
		// calibration overwrites, winning over a host write in the same cycle
		if (cal_in.valid) begin
			if (cal_in.target) begin
				n.gain[cal_in.gidx] = cal_in.data; // [RQ9]
			end else begin
				n.off = cal_in.data; // [RQ3]
			end
		end
		n.awready = !n.aw_got && !n.bvalid;
		n.wready  = !n.w_got && !n.bvalid;
		// read channel, answered the cycle after address is taken
		if (st.rvalid && rready) begin
			n.rvalid = 1'b0;
		end
		if (arvalid && st.arready) begin
			n.rvalid = 1'b1;
			n.rresp  = rdec.hit ? RESP_OKAY : RESP_SLVERR;
			n.rdata  = '0;
			case (rdec.kind)
				K_OFF: begin
					n.rdata[WORD_W-1:0] = st.off;
				end
				K_GAIN: begin
					n.rdata[WORD_W-1:0] = st.gain[rdec.gidx];
				end
				K_EXT_OFF: begin
					n.rdata[WORD_W-1:0] = st.ext_off;
				end
				K_EXT_GAIN: begin
					n.rdata[WORD_W-1:0] = st.ext_gain;
				end
				K_RES: begin
					n.rdata[WORD_W-1:0] = st.res.data;
				end
				default: begin
					if (rdec.hit) begin
						n.rdata[CTRL_W-1:0] = st.ctrl;
					end
				end
			endcase
		end
		n.arready = !n.rvalid;
		// internal offset then internal gain [RQ4] [RQ5]
		n.s1.valid = raw_in.valid;
		if (raw_in.valid) begin
			n.s1.data = mul1;
		end
		// system offset then system gain [RQ13]
		n.s2.valid = st.s1.valid;
		if (st.s1.valid) begin
			n.s2.data = mul2;
		end
		// unipolar doubling last [RQ5] [RQ13] [RQ14]
		n.res.valid = st.s2.valid;
		if (st.s2.valid) begin
			n.res.data = st.ctrl.polarity_select ? sat_dbl(st.s2.data) : st.s2.data;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= STATE_RST;
		end else begin
			st <= n;
		end
	end

	assign awready      = st.awready;
	assign wready       = st.wready;
	assign bvalid       = st.bvalid;
	assign bresp        = st.bresp;
	assign arready      = st.arready;
	assign rvalid       = st.rvalid;
	assign rresp        = st.rresp;
	assign rdata        = st.rdata;
	assign result_data  = st.res.data;
	assign result_valid = st.res.valid;

	// checks
	logic quiet;
	logic off_touch;
	logic gain_touch;
	assign quiet = !wr_commit && !cal_in.valid && !st.ctrl.ext_offset_en
		&& !st.ctrl.ext_gain_en && st.gain[st.ctrl.gain_sel] == GAIN_UNITY;
	assign off_touch  = cal_in.valid && !cal_in.target;
	assign gain_touch = cal_in.valid && cal_in.target;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_quiet_path;
		quiet [*3];
	endsequence

	sequence s_bipolar_raw;
		raw_in.valid && !st.ctrl.polarity_select ##0 s_quiet_path;
	endsequence

	chk_offset_bypass: assert property ( // [RQ1]
		st.ctrl.internal_offset_disable ##0 s_bipolar_raw
		|=> result_valid && result_data == $past(raw_in.data, 3))
		else $error("disabled offset still altered result");

	chk_offset_subtract: assert property ( // [RQ2]
		!st.ctrl.internal_offset_disable ##0 s_bipolar_raw
		|=> result_data == sat_sub($past(raw_in.data, 3), $past(st.off, 3)))
		else $error("offset subtraction result wrong");

	chk_unipolar_order: assert property ( // [RQ5]
		raw_in.valid && st.ctrl.polarity_select && !st.ctrl.internal_offset_disable
		##0 s_quiet_path
		|=> result_data == sat_dbl(sat_sub($past(raw_in.data, 3), $past(st.off, 3))))
		else $error("doubling not applied after offset");

	chk_pipe_latency: assert property ( // [RQ4]
		raw_in.valid |-> ##3 result_valid)
		else $error("result missing three cycles after sample");

	chk_no_spurious: assert property ( // [RQ4]
		result_valid |-> $past(raw_in.valid, 3))
		else $error("result without a sample");

	chk_offset_hold: assert property ( // [RQ3]
		!off_touch && !(wr_commit && wdec.kind == K_OFF && wdec.hit) |=> $stable(st.off))
		else $error("offset changed without write or calibration");

	chk_gain_hold: assert property ( // [RQ9]
		!gain_touch && !(wr_commit && wdec.kind == K_GAIN) |=> $stable(st.gain))
		else $error("gain changed without write or calibration");

	chk_cal_load: assert property ( // [RQ9]
		gain_touch |=> st.gain[$past(cal_in.gidx)] == $past(cal_in.data))
		else $error("calibration gain not stored");

	chk_sat_high: assert property ( // [RQ14]
		(raw_in.data == WORD_MAX && st.off[23] && !st.ctrl.internal_offset_disable)
		##0 s_bipolar_raw
		|=> result_data == WORD_MAX)
		else $error("positive overflow wrapped");

	chk_bresp_hold: assert property (
		bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
endmodule

// ### bench/tb_self_calibration_correction.sv
// self-checking bench of the self-calibration correction stage
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
	$display("FAIL %0t: got %h expected %h", $time, (a), (b)); end end
module tb_self_calibration_correction
	import scc_pkg::*;
;
	logic              aclk;
	logic              aresetn;
	logic [AXI_AW-1:0] awaddr;
	logic              awvalid;
	logic              awready;
	logic [AXI_DW-1:0] wdata;
	logic [3:0]        wstrb;
	logic              wvalid;
	logic              wready;
	logic [1:0]        bresp;
	logic              bvalid;
	logic              bready;
	logic [AXI_AW-1:0] araddr;
	logic              arvalid;
	logic              arready;
	logic [AXI_DW-1:0] rdata;
	logic [1:0]        rresp;
	logic              rvalid;
	logic              rready;
	scc_sample_t       raw_in;
	scc_cal_t          cal_in;
	scc_word_t         result_data;
	logic              result_valid;
	int                fails;
	int                n_checks;

	scc_top DUT (
		.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.raw_in(raw_in), .cal_in(cal_in),
		.result_data(result_data), .result_valid(result_valid)
	);

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	function automatic logic [7:0] ba(input logic [5:0] idx);
		return {idx, 2'b00};
	endfunction

	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// write with both channels offered together, response checked
	task automatic axi_wr(input logic [5:0] idx, input logic [31:0] d, input logic [1:0] er);
		int   n;
		logic aw_d;
		logic w_d;
		@(posedge aclk);
		awaddr  <= ba(idx);
		wdata   <= d;
		wstrb   <= 4'hf;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		aw_d = 1'b0;
		w_d = 1'b0;
		n = 0;
		while (!(aw_d && w_d) && n < 50) begin
			@(posedge aclk);
			n++;
			if (!aw_d && awready) begin
				aw_d = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_d && wready) begin
				w_d = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (!bvalid && n < 50) begin
			@(posedge aclk);
			n++;
		end
		// response left waiting one cycle before it is accepted
		bready <= 1'b1;
		@(posedge aclk);
		if (n >= 50) begin
			fails++;
			$display("FAIL %0t: write timed out", $time);
		end
		`CHK(bvalid, 1'b1)
		`CHK(bresp, er)
		bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (!arready && n < 50);
		arvalid <= 1'b0;
		do begin
			@(posedge aclk);
			n++;
		end while (!rvalid && n < 50);
		if (n >= 50) begin
			fails++;
			$display("FAIL %0t: read timed out", $time);
		end
		`CHK(rdata, ed)
		`CHK(rresp, er)
		rready <= 1'b0;
	endtask

	// one raw sample, result expected exactly three edges after it is driven
	task automatic conv(input logic [23:0] d, input logic [23:0] e);
		@(posedge aclk);
		raw_in <= '{valid: 1'b1, data: d};
		@(posedge aclk);
		raw_in.valid <= 1'b0;
		repeat (1) begin
			@(posedge aclk);
			#1;
			`CHK(result_valid, 1'b0)
		end
		@(posedge aclk);
		#1;
		`CHK(result_valid, 1'b1)
		`CHK(result_data, e)
	endtask

	task automatic cal(input logic t, input logic [2:0] g, input logic [23:0] d);
		@(posedge aclk);
		cal_in <= '{valid: 1'b1, target: t, gidx: g, data: d};
		@(posedge aclk);
		cal_in.valid <= 1'b0;
	endtask

	task automatic t_reset();
		axi_rd(ba(IDX_INT_OFFSET), 32'h00000000, RESP_OKAY);
		axi_rd(ba(IDX_INT_GAIN_X1), 32'h00800000, RESP_OKAY);
		axi_rd(8'h00, 32'h00000000, RESP_SLVERR);
		axi_wr(IDX_RESULT, 32'h00000123, RESP_SLVERR);
		$display("test reset done");
	endtask

	task automatic t_offset();
		axi_wr(IDX_INT_OFFSET, 32'h00000010, RESP_OKAY);
		axi_rd(ba(IDX_INT_OFFSET), 32'h00000010, RESP_OKAY);
		conv(24'h000100, 24'h0000f0);
		axi_wr(IDX_INT_OFFSET, 32'h00fffff0, RESP_OKAY);
		conv(24'h000100, 24'h000110);
		axi_wr(IDX_CTRL, 32'h00000001, RESP_OKAY);
		conv(24'h000100, 24'h000100);
		axi_wr(IDX_CTRL, 32'h00000000, RESP_OKAY);
		$display("test offset done");
	endtask

	task automatic t_gain();
		axi_wr(IDX_INT_OFFSET, 32'h00000000, RESP_OKAY);
		axi_wr(IDX_INT_GAIN_X2, 32'h00c00000, RESP_OKAY);
		axi_wr(IDX_INT_GAIN_X4, 32'h00400000, RESP_OKAY);
		axi_wr(IDX_CTRL, 32'h00000004, RESP_OKAY);
		conv(24'h001000, 24'h001800);
		conv(24'hfff000, 24'hffe800);
		axi_wr(IDX_CTRL, 32'h00000008, RESP_OKAY);
		conv(24'h001000, 24'h000800);
		axi_wr(IDX_INT_GAIN_X4, 32'h00ffffff, RESP_OKAY);
		conv(24'h100000, 24'h200000);
		conv(24'h400000, 24'h7fffff);
		axi_wr(IDX_CTRL, 32'h00000000, RESP_OKAY);
		conv(24'h001000, 24'h001000);
		$display("test gain done");
	endtask

	task automatic t_sat();
		axi_wr(IDX_INT_OFFSET, 32'h00000001, RESP_OKAY);
		conv(24'h800000, 24'h800000);
		axi_wr(IDX_INT_OFFSET, 32'h00ffffff, RESP_OKAY);
		conv(24'h7fffff, 24'h7fffff);
		$display("test saturation done");
	endtask

	task automatic t_order();
		axi_wr(IDX_INT_OFFSET, 32'h00000010, RESP_OKAY);
		axi_wr(IDX_CTRL, 32'h00000002, RESP_OKAY);
		conv(24'h000110, 24'h000200);
		axi_wr(IDX_INT_GAIN_X1, 32'h00c00000, RESP_OKAY);
		axi_wr(IDX_CTRL, 32'h00000002, RESP_OKAY);
		conv(24'h000110, 24'h000300);
		axi_wr(IDX_EXT_OFFSET_B, 32'h00000080, RESP_OKAY);
		axi_wr(IDX_CTRL, 32'h00000022, RESP_OKAY);
		conv(24'h000110, 24'h000200);
		axi_wr(IDX_EXT_GAIN_B, 32'h00400000, RESP_OKAY);
		axi_wr(IDX_CTRL, 32'h00000062, RESP_OKAY);
		axi_rd(ba(IDX_CTRL), 32'h00000062, RESP_OKAY);
		conv(24'h000110, 24'h000100);
		axi_wr(IDX_CTRL, 32'h00000000, RESP_OKAY);
		conv(24'h000110, 24'h000180);
		$display("test order done");
	endtask

	task automatic t_cal();
		cal(1'b0, 3'h0, 24'h000020);
		axi_rd(ba(IDX_INT_OFFSET), 32'h00000020, RESP_OKAY);
		cal(1'b1, 3'h0, 24'h800000);
		conv(24'h000100, 24'h0000e0);
		axi_rd(ba(IDX_RESULT), 32'h000000e0, RESP_OKAY);
		cal(1'b1, 3'h1, 24'ha00000);
		axi_rd(ba(IDX_INT_GAIN_X2), 32'h00a00000, RESP_OKAY);
		axi_rd(ba(IDX_INT_GAIN_X1), 32'h00800000, RESP_OKAY);
		$display("test calibration done");
	endtask

	initial begin
		fails = 0;
		n_checks = 0;
		aresetn = 1'b0;
		awaddr = '0;
		awvalid = 1'b0;
		wdata = '0;
		wstrb = '0;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = '0;
		arvalid = 1'b0;
		rready = 1'b0;
		raw_in = '0;
		cal_in = '0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_offset();
		t_gain();
		t_sat();
		t_order();
		t_cal();
		summarize();
	end

	// hang guard, far beyond the few hundred cycles the tests need
	initial begin
		#200000;
		fails++;
		$display("FAIL %0t: watchdog expired", $time);
		summarize();
	end
endmodule
